// ---- hw/uoe_pkg.sv ----
// Shared constants and types for the OUT endpoint control block
package uoe_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL_LOW   = 8'h14;
  localparam logic [7:0] IDX_CTRL_HIGH  = 8'h15;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
  localparam logic [7:0] IDX_IRQ_CLEAR  = 8'h21;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h22;
  localparam int         IDX_LSB        = 2;
  localparam int         IDX_MSB        = 9;

  // Low control byte fields
  localparam int LO_STALL_SENT  = 6;
  localparam int LO_SEND_STALL  = 5;
  localparam int LO_FLUSH       = 4;
  localparam int LO_DATA_ERR    = 3;
  localparam int LO_OVERRUN     = 2;
  localparam int LO_FULL        = 1;
  localparam int LO_PKT_READY   = 0;

  // High control byte fields
  localparam int HI_DBL_BUF     = 7;
  localparam int HI_ISO         = 6;
  localparam int HI_UNUSED_MSB  = 5;

  // Interrupt status, clear and enable layout
  localparam int IRQ_N          = 4;
  localparam int IRQ_PKT_READY  = 0;
  localparam int IRQ_STALL_SENT = 1;
  localparam int IRQ_OVERRUN    = 2;
  localparam int IRQ_DATA_ERR   = 3;

  // Packet capacity of the OUT FIFO
  localparam logic [1:0] PKT_SINGLE = 2'h1;
  localparam logic [1:0] PKT_DOUBLE = 2'h2;

  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic        ap_valid;
    logic        ap_write;
    logic [7:0]  ap_index;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        send_stall;
    logic        stall_sent;
    logic        flush;
    logic        data_err;
    logic        overrun;
    logic        pkt_ready;
    logic        dbl_buf;
    logic        iso;
    logic        reply_ack;
    logic        reply_nak;
    logic        reply_stall;
    logic        rd_ptr_reset;
  } uoe_ep_state_t;

  typedef struct packed {
    logic [1:0] count;
    logic       full;
  } uoe_occ_state_t;

  typedef struct packed {
    logic [IRQ_N-1:0] status;
    logic [IRQ_N-1:0] enable;
    logic             irq;
  } uoe_irq_state_t;
endpackage : uoe_pkg

// ---- hw/uoe_occupancy.sv ----
// Packet occupancy counter of the OUT FIFO with full flag
`timescale 1ns/100ps
`default_nettype none
module uoe_occupancy (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       dbl_buf,
  input  wire logic       push,
  input  wire logic       pop,
  output logic      [1:0] count,
  output logic            full
);
  uoe_pkg::uoe_occ_state_t s;
  uoe_pkg::uoe_occ_state_t next_s;
  logic [1:0] limit;

  always_comb begin
    next_s = s;
    limit  = dbl_buf ? uoe_pkg::PKT_DOUBLE : uoe_pkg::PKT_SINGLE;
    // Caller never pushes into a full FIFO; an empty pop is ignored
    if (push && !(pop && s.count != 2'h0)) begin
      next_s.count = s.count + 2'h1;
    end else if (pop && !push && s.count != 2'h0) begin
      next_s.count = s.count - 2'h1;
    end
    next_s.full = (next_s.count >= limit);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign count = s.count;
  assign full  = s.full;

  // Mode change reflects one cycle later
  AST_FULL_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
    $stable(dbl_buf) |->
      full == (count >= (dbl_buf ? uoe_pkg::PKT_DOUBLE : uoe_pkg::PKT_SINGLE)))
    else $error("Full flag does not match packet count");
endmodule : uoe_occupancy
`default_nettype wire

// ---- hw/uoe_irq.sv ----
// Sticky interrupt status with enable, write-one clear and level output
`timescale 1ns/100ps
`default_nettype none
module uoe_irq #(
  parameter int N = 4
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [N-1:0] event_in,
  input  wire logic         clear_wr,
  input  wire logic         enable_wr,
  input  wire logic [N-1:0] wdata,
  output logic      [N-1:0] status,
  output logic      [N-1:0] enable,
  output logic              irq
);
  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] enable;
    logic         irq;
  } uoe_irq_local_t;
  uoe_irq_local_t s;
  uoe_irq_local_t next_s;
  logic [N-1:0]   next_status;

  // Set beats clear so no event is lost
  for (genvar i = 0; i < N; i++) begin : g_bit
    assign next_status[i] = event_in[i] |
                            (s.status[i] & ~(clear_wr & wdata[i]));
  end

  always_comb begin
    next_s        = s;
    next_s.status = next_status;
    if (enable_wr) begin
      next_s.enable = wdata;
    end
    next_s.irq = |(next_status & next_s.enable);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign status = s.status;
  assign enable = s.enable;
  assign irq    = s.irq;
endmodule : uoe_irq
`default_nettype wire

// ---- hw/uoe_out_endpoint.sv ----
// OUT endpoint control and status with AHB-Lite register slave
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Send-stall does nothing in isochronous mode; clearing it ends stalling.
// - Flush write discards next packet, resets read pointer, clears ready.
// - One packet per flush; flush bit returns to zero once done.
// - Packet arriving to a full FIFO sets overrun in isochronous mode.
// - Overrun stays one until software clears it, else reads zero.
// - Full means two packets double-buffered, one packet otherwise.
// - High byte bit seven selects double buffering.
// - High byte bit six selects isochronous versus bulk or interrupt.
// - High byte bits five to zero read zero, writes ignored.
// - Stall set: every bulk or interrupt OUT answered STALL, stall-sent set, interrupt raised if its enable bit is set.
// - Packet-ready sets per buffered packet, again after first is unloaded.
module uoe_out_endpoint (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rx_valid,
  input  wire logic        rx_crc_err,
  input  wire logic        rx_stuff_err,
  output logic             reply_ack,
  output logic             reply_nak,
  output logic             reply_stall,
  output logic             rd_ptr_reset,
  output logic             irq
);
  uoe_pkg::uoe_ep_state_t s;
  uoe_pkg::uoe_ep_state_t next_s;

  logic [1:0]               pkt_count;
  logic                     fifo_full;
  logic                     push;
  logic                     pop;
  logic [uoe_pkg::IRQ_N-1:0] events;
  logic [uoe_pkg::IRQ_N-1:0] irq_status;
  logic [uoe_pkg::IRQ_N-1:0] irq_enable;
  logic                     wr_low;
  logic                     wr_high;
  logic                     wr_clear;
  logic                     wr_enable;
  logic [7:0]               wd;
  logic [7:0]               rd_byte;
  logic [7:0]               low_byte;
  logic [7:0]               high_byte;
  logic [7:0]               addr_index;
  logic                     ap_take;

  uoe_occupancy u_occ (
    .hclk    (hclk),
    .hresetn (hresetn),
    .dbl_buf (s.dbl_buf),
    .push    (push),
    .pop     (pop),
    .count   (pkt_count),
    .full    (fifo_full)
  );

  uoe_irq #(
    .N (uoe_pkg::IRQ_N)
  ) u_irq (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .event_in  (events),
    .clear_wr  (wr_clear),
    .enable_wr (wr_enable),
    .wdata     (wd[uoe_pkg::IRQ_N-1:0]),
    .status    (irq_status),
    .enable    (irq_enable),
    .irq       (irq)
  );

  // Write side decode in the data phase
  assign wd        = hwdata[7:0];
  assign wr_low    = s.ap_valid && s.ap_write &&
                     s.ap_index == uoe_pkg::IDX_CTRL_LOW;
  assign wr_high   = s.ap_valid && s.ap_write &&
                     s.ap_index == uoe_pkg::IDX_CTRL_HIGH;
  assign wr_clear  = s.ap_valid && s.ap_write &&
                     s.ap_index == uoe_pkg::IDX_IRQ_CLEAR;
  assign wr_enable = s.ap_valid && s.ap_write &&
                     s.ap_index == uoe_pkg::IDX_IRQ_ENABLE;
  assign ap_take    = hsel && htrans[1] && hready;
  assign addr_index = haddr[uoe_pkg::IDX_MSB:uoe_pkg::IDX_LSB];

  // Data-toggle clear bit always reads zero
  assign low_byte = {1'b0, s.stall_sent, s.send_stall, s.flush,
                     s.data_err, s.overrun, fifo_full, s.pkt_ready};
  assign high_byte = {s.dbl_buf, s.iso,
                      6'h00};

  always_comb begin
    case (addr_index)
      uoe_pkg::IDX_CTRL_LOW:   rd_byte = low_byte;
      uoe_pkg::IDX_CTRL_HIGH:  rd_byte = high_byte;
      uoe_pkg::IDX_IRQ_STATUS: rd_byte = {4'h0, irq_status};
      uoe_pkg::IDX_IRQ_ENABLE: rd_byte = {4'h0, irq_enable};
      default:                 rd_byte = uoe_pkg::BYTE_ZERO;
    endcase
  end

  always_comb begin
    next_s              = s;
    next_s.hreadyout    = 1'b1;
    next_s.hresp        = 1'b0;
    next_s.reply_ack    = 1'b0;
    next_s.reply_nak    = 1'b0;
    next_s.reply_stall  = 1'b0;
    next_s.rd_ptr_reset = 1'b0;
    push                = 1'b0;
    pop                 = 1'b0;
    events              = '0;

    // Address phase; read data is prepared for the data phase
    next_s.ap_valid = ap_take;
    next_s.ap_write = hwrite;
    next_s.ap_index = addr_index;
    next_s.hrdata   = (ap_take && !hwrite) ?
                      {24'h000000, rd_byte} : uoe_pkg::WORD_ZERO;

    // Software writes to the control bytes
    if (wr_low) begin
      next_s.send_stall = wd[uoe_pkg::LO_SEND_STALL];
      if (!wd[uoe_pkg::LO_STALL_SENT]) begin
        next_s.stall_sent = 1'b0;
      end
      if (!wd[uoe_pkg::LO_OVERRUN]) begin
        next_s.overrun = 1'b0;
      end
      if (wd[uoe_pkg::LO_FLUSH]) begin
        next_s.flush = 1'b1;
      end
      // Unloading a packet: clearing ready pops it and its error flag
      // A flush write unloads through the flush path only
      if (!wd[uoe_pkg::LO_PKT_READY] && s.pkt_ready && !s.flush &&
          !wd[uoe_pkg::LO_FLUSH]) begin
        next_s.pkt_ready = 1'b0;
        next_s.data_err  = 1'b0;
        pop              = 1'b1;
      end
    end
    if (wr_high) begin
      next_s.dbl_buf = wd[uoe_pkg::HI_DBL_BUF];
      next_s.iso     = wd[uoe_pkg::HI_ISO];
    end

    // A flush takes one cycle and removes exactly one packet
    if (s.flush) begin
      pop                 = 1'b1;
      next_s.rd_ptr_reset = 1'b1;
      next_s.pkt_ready    = 1'b0;
      next_s.data_err     = 1'b0;
      next_s.flush        = 1'b0;
    end else if (!s.pkt_ready && pkt_count != 2'h0 && !pop) begin
      // Second buffered packet is announced right after the first leaves
      next_s.pkt_ready              = 1'b1;
      events[uoe_pkg::IRQ_PKT_READY] = 1'b1;
    end

    // Incoming OUT packet; hardware sets win over software clears
    if (rx_valid) begin
      if (s.send_stall && !s.iso) begin
        next_s.reply_stall             = 1'b1;
        next_s.stall_sent              = 1'b1;
        events[uoe_pkg::IRQ_STALL_SENT] = 1'b1;
      end else if (fifo_full) begin
        if (s.iso) begin
          next_s.overrun               = 1'b1;
          events[uoe_pkg::IRQ_OVERRUN] = 1'b1;
        end else begin
          next_s.reply_nak = 1'b1;
        end
      end else if (s.iso) begin
        // Errored isochronous data is still stored, only flagged
        push = 1'b1;
        if (rx_crc_err || rx_stuff_err) begin
          next_s.data_err               = 1'b1;
          events[uoe_pkg::IRQ_DATA_ERR] = 1'b1;
        end
      end else if (!(rx_crc_err || rx_stuff_err)) begin
        // Corrupt bulk data gets no handshake so the host retries
        push             = 1'b1;
        next_s.reply_ack = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign hrdata       = s.hrdata;
  assign hreadyout    = s.hreadyout;
  assign hresp        = s.hresp;
  assign reply_ack    = s.reply_ack;
  assign reply_nak    = s.reply_nak;
  assign reply_stall  = s.reply_stall;
  assign rd_ptr_reset = s.rd_ptr_reset;

  AST_ISO_NO_STALL: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_valid && s.iso |=> !reply_stall)
    else $error("Stall sent in isochronous mode");

  AST_STALL_REPLY: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_valid && s.send_stall && !s.iso |=> reply_stall && s.stall_sent
      && irq_status[uoe_pkg::IRQ_STALL_SENT])
    else $error("Stall request not answered with stall");

  AST_FLUSH_DONE: assert property (@(posedge hclk) disable iff (!hresetn)
    s.flush |=> !s.flush && rd_ptr_reset && !s.pkt_ready)
    else $error("Flush did not complete in one cycle");

  AST_FLUSH_POP: assert property (@(posedge hclk) disable iff (!hresetn)
    s.flush && pkt_count != 2'h0 && !push |=>
      pkt_count == $past(pkt_count) - 2'h1)
    else $error("Flush did not remove exactly one packet");

  AST_DATA_ERR: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_valid && s.iso && !fifo_full && (rx_crc_err || rx_stuff_err)
      |=> s.data_err ##1 s.pkt_ready || s.flush || $past(pop))
    else $error("Isochronous error packet not flagged");

  AST_OVERRUN_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_valid && s.iso && fifo_full && !(s.send_stall && !s.iso)
      |=> s.overrun && !reply_ack)
    else $error("Overrun not flagged on full FIFO");

  AST_OVERRUN_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    s.overrun && !(wr_low && !wd[uoe_pkg::LO_OVERRUN]) |=> s.overrun)
    else $error("Overrun cleared without software");

  AST_HIGH_RESERVED: assert property (@(posedge hclk) disable iff (!hresetn)
    s.ap_valid && !s.ap_write && s.ap_index == uoe_pkg::IDX_CTRL_HIGH
      |-> hrdata[uoe_pkg::HI_UNUSED_MSB:0] == 6'h00)
    else $error("Unused high byte bits read nonzero");

  AST_READY_REARM: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_low && pop && pkt_count == 2'h2 |=> !s.pkt_ready ##1 s.pkt_ready)
    else $error("Second packet not announced after unload");
endmodule : uoe_out_endpoint
`default_nettype wire

// ---- sim/uoe_host_model.sv ----
// Behavioural host that sends OUT packets to the endpoint
`timescale 1ns/100ps
`default_nettype none
module uoe_host_model (
  input  wire logic hclk,
  output logic      rx_valid,
  output logic      rx_crc_err,
  output logic      rx_stuff_err
);
  logic sending = 1'b0;
  logic crc_q   = 1'b0;
  logic stuff_q = 1'b0;
  logic churn   = 1'b0;
  // Qualifiers mean nothing between packets, so they churn there
  always @(posedge hclk) begin
    churn <= ~churn;
  end
  assign rx_valid     = sending;
  assign rx_crc_err   = sending ? crc_q : churn;
  assign rx_stuff_err = sending ? stuff_q : ~churn;
  task automatic send(input logic crc, input logic stuff);
    sending <= 1'b1;
    crc_q   <= crc;
    stuff_q <= stuff;
    @(posedge hclk);
    sending <= 1'b0;
  endtask : send
endmodule : uoe_host_model
`default_nettype wire

// ---- sim/tb.sv ----
// Testbench for the OUT endpoint control block
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [7:0] a_lo = uoe_pkg::IDX_CTRL_LOW;
  localparam logic [7:0] a_hi = uoe_pkg::IDX_CTRL_HIGH;
  localparam logic [7:0] a_st = uoe_pkg::IDX_IRQ_STATUS;
  localparam logic [7:0] a_cl = uoe_pkg::IDX_IRQ_CLEAR;
  localparam logic [7:0] a_en = uoe_pkg::IDX_IRQ_ENABLE;
  logic        hclk = 1'b0;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        rx_valid;
  logic        rx_crc_err;
  logic        rx_stuff_err;
  logic        reply_ack;
  logic        reply_nak;
  logic        reply_stall;
  logic        rd_ptr_reset;
  logic        irq;
  logic [31:0] rd;
  int          err_count = 0;
  int          total_checks = 0;
  int          ptr_resets = 0;
  always #4 hclk = ~hclk;
  always @(posedge hclk) begin
    if (rd_ptr_reset === 1'b1) ptr_resets++;
  end
  uoe_out_endpoint i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rx_valid(rx_valid), .rx_crc_err(rx_crc_err),
    .rx_stuff_err(rx_stuff_err), .reply_ack(reply_ack),
    .reply_nak(reply_nak), .reply_stall(reply_stall),
    .rd_ptr_reset(rd_ptr_reset), .irq(irq)
  );
  uoe_host_model i_host (
    .hclk(hclk), .rx_valid(rx_valid), .rx_crc_err(rx_crc_err),
    .rx_stuff_err(rx_stuff_err)
  );
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [31:0] wd);
    hsel   <= 1'b1;
    hwrite <= w;
    htrans <= 2'h2;
    haddr  <= {22'h000000, idx, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d);
    // Read data is captured in the address phase, so let the write settle
    @(posedge hclk);
  endtask : wr
  task automatic rdchk(input string n, input logic [7:0] idx,
                       input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    check(n, rd, exp);
  endtask : rdchk
  // Reply order in exp: ack, nak, stall
  task automatic pkt(input logic crc, input logic stuff,
                     input logic [2:0] exp);
    i_host.send(crc, stuff);
    @(posedge hclk);
    check("reply", {29'h0, reply_ack, reply_nak, reply_stall}, {29'h0, exp});
  endtask : pkt
  task automatic t_reset();
    rdchk("low", a_lo, 32'h0);
    rdchk("high", a_hi, 32'h0);
    rdchk("status", a_st, 32'h0);
    rdchk("enable", a_en, 32'h0);
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask : t_reset
  task automatic t_high();
    wr(a_hi, 32'hFF);
    rdchk("high", a_hi, 32'hC0);
    wr(a_hi, 32'h0);
    wr(8'h30, 32'hFF);
    rdchk("unmapped", 8'h30, 32'h0);
  endtask : t_high
  task automatic t_bulk();
    pkt(1'b1, 1'b0, 3'h0);
    rdchk("low", a_lo, 32'h0);
    pkt(1'b0, 1'b0, 3'h4);
    rdchk("low", a_lo, 32'h03);
    pkt(1'b0, 1'b0, 3'h2);
    rdchk("low", a_lo, 32'h03);
    wr(a_lo, 32'h0);
    rdchk("low", a_lo, 32'h0);
  endtask : t_bulk
  task automatic t_double();
    int n;
    wr(a_hi, 32'h80);
    pkt(1'b0, 1'b0, 3'h4);
    pkt(1'b0, 1'b0, 3'h4);
    rdchk("low", a_lo, 32'h03);
    wr(a_lo, 32'h0);
    rdchk("low", a_lo, 32'h01);
    n = ptr_resets;
    // Whole packet still unread, so flushing is allowed
    wr(a_lo, 32'h10);
    rdchk("low", a_lo, 32'h0);
    check("ptr reset", ptr_resets, n + 1);
    wr(a_hi, 32'h0);
  endtask : t_double
  task automatic t_stall();
    wr(a_cl, 32'hF);
    wr(a_en, 32'h2);
    wr(a_lo, 32'h20);
    pkt(1'b0, 1'b0, 3'h1);
    rdchk("low", a_lo, 32'h60);
    rdchk("status", a_st, 32'h2);
    check("irq", {31'h0, irq}, 32'h1);
    wr(a_cl, 32'h2);
    rdchk("status", a_st, 32'h0);
    check("irq", {31'h0, irq}, 32'h0);
    wr(a_lo, 32'h0);
    pkt(1'b0, 1'b0, 3'h4);
    rdchk("status", a_st, 32'h1);
    check("masked irq", {31'h0, irq}, 32'h0);
    rdchk("enable", a_en, 32'h2);
    wr(a_lo, 32'h0);
    wr(a_cl, 32'hF);
  endtask : t_stall
  task automatic t_iso();
    wr(a_hi, 32'h40);
    wr(a_lo, 32'h20);
    pkt(1'b0, 1'b0, 3'h0);
    rdchk("low", a_lo, 32'h23);
    pkt(1'b0, 1'b0, 3'h0);
    rdchk("low", a_lo, 32'h27);
    wr(a_lo, 32'h05);
    rdchk("low", a_lo, 32'h07);
    wr(a_lo, 32'h01);
    rdchk("low", a_lo, 32'h03);
    wr(a_lo, 32'h0);
    pkt(1'b1, 1'b0, 3'h0);
    rdchk("low", a_lo, 32'h0B);
    wr(a_lo, 32'h0);
    rdchk("low", a_lo, 32'h0);
    pkt(1'b0, 1'b1, 3'h0);
    rdchk("low", a_lo, 32'h0B);
    wr(a_lo, 32'h10);
    rdchk("low", a_lo, 32'h0);
    rdchk("status", a_st, 32'hD);
    wr(a_hi, 32'h0);
  endtask : t_iso
  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    results();
  end
  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hwdata  = 32'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_high();
    t_bulk();
    t_double();
    t_stall();
    t_iso();
    results();
  end
endmodule : tb
`default_nettype wire
